// [hw/plc_bank.sv]
// Line termination, receive gain, gap and indicator source registers.
// Assumes a single clock domain and a simple strobe register port.
`timescale 1ns/1ps
`include "plc_defs.svh"

module plc_bank (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [10:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire plc_pkg::plc_status_t i_status,
    output logic [15:0] o_rdata,
    output plc_pkg::plc_line_cfg_t o_line_cfg,
    output logic [2:0] o_led
);

    // Register storage
    logic [15:0] term_reg;
    logic [15:0] ldprog_reg;
    logic [15:0] gain_reg;
    logic [15:0] general_config_reg;
    logic [15:0] ledsel_reg;
    logic [15:0] rdata_reg;
    plc_pkg::plc_line_cfg_t line_reg;
    logic [2:0] led_reg;
    // Sticky indicator states
    logic link_lost_reg;
    logic prbs_hold_reg;
    logic link_prev_reg;
    // Blink timer
    logic [19:0] blink_cnt_reg;
    logic blink_reg;

    logic link_drop;
    logic status_read;
    logic [2:0] led_next;

    // Falling link and read of the basic status word
    assign link_drop = link_prev_reg & ~i_status.link_up;
    assign status_read = i_rd && (i_addr == `PLC_OFF_BASIC_STATUS);

    // Register writes
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            term_reg <= `PLC_RST_TERM;
            ldprog_reg <= `PLC_RST_LDPROG;
            gain_reg <= `PLC_RST_GAIN;
            general_config_reg <= `PLC_RST_GENERAL_CONFIG;
            ledsel_reg <= `PLC_RST_LEDSEL;
        end
        else if (i_wr)
        begin
            case (i_addr)
                // Codes and override enables; bits 1-0 read zero
                `PLC_OFF_TERM: term_reg <= i_wdata & `PLC_WMASK_TERM;
                `PLC_OFF_LDPROG: ldprog_reg <= i_wdata;
                `PLC_OFF_GAIN: gain_reg <= i_wdata & `PLC_WMASK_GAIN;
                `PLC_OFF_GENERAL_CONFIG: general_config_reg <= i_wdata;
                `PLC_OFF_LEDSEL: ledsel_reg <= i_wdata;
                default: ;
            endcase
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            rdata_reg <= 16'h0000;
        else if (i_rd)
        begin
            case (i_addr)
                `PLC_OFF_TERM: rdata_reg <= term_reg;
                `PLC_OFF_LDPROG: rdata_reg <= ldprog_reg;
                `PLC_OFF_GAIN: rdata_reg <= gain_reg;
                `PLC_OFF_GENERAL_CONFIG: rdata_reg <= general_config_reg;
                `PLC_OFF_LEDSEL: rdata_reg <= ledsel_reg;
                // Unmapped addresses read zero
                default: rdata_reg <= 16'h0000;
            endcase
        end
        else
            rdata_reg <= 16'h0000;
    end

    // Line configuration outputs, registered
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            line_reg <= '0;
        else
        begin
            line_reg.straight_termination_code <=
                term_reg[`PLC_STR_CODE_HI:`PLC_STR_CODE_LO];
            line_reg.straight_termination_override <=
                term_reg[`PLC_STR_OVR_BIT];
            line_reg.crossed_termination_code <=
                term_reg[`PLC_CRS_CODE_HI:`PLC_CRS_CODE_LO];
            line_reg.crossed_termination_override <=
                term_reg[`PLC_CRS_OVR_BIT];
            line_reg.rx_comparator_gain <=
                gain_reg[`PLC_GAIN_HI:`PLC_GAIN_LO];
            line_reg.short_gap_select <=
                general_config_reg[`PLC_SHORT_GAP_BIT];
            // Gap length in clock cycles for the transmit path
            line_reg.min_gap_cycles <= general_config_reg[`PLC_SHORT_GAP_BIT]
                ? 3'(`PLC_GAP_SHORT_CYC)
                : 3'(`PLC_GAP_LONG_CYC);
        end
    end

    // Link-lost latch: set wins over the clearing read
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            link_lost_reg <= 1'b0;
            link_prev_reg <= 1'b0;
        end
        else
        begin
            link_prev_reg <= i_status.link_up;
            if (link_drop)
                link_lost_reg <= 1'b1;
            else if (status_read)
                link_lost_reg <= 1'b0;
        end
    end

    // PRBS error latch: one error lights it until counter clear
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            prbs_hold_reg <= 1'b0;
        else if (i_status.prbs_err)
            prbs_hold_reg <= 1'b1;
        else if (i_status.prbs_clear)
            prbs_hold_reg <= 1'b0;
    end

    // Blink timer for link-with-activity source
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            blink_cnt_reg <= 20'h00000;
            blink_reg <= 1'b0;
        end
        else if (blink_cnt_reg == `PLC_BLINK_CYC - 20'd1)
        begin
            blink_cnt_reg <= 20'h00000;
            blink_reg <= ~blink_reg;
        end
        else
            blink_cnt_reg <= blink_cnt_reg + 20'd1;
    end

    // Source multiplexer, one per indicator
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_led
            plc_pkg::plc_src_t sel;
            // Nibble g+1 of the selector word: first, second, third
            assign sel =
                plc_pkg::plc_src_t'(ledsel_reg[4*g+7 -: 4]);
            always_comb
            begin
                case (sel)
                    plc_pkg::PLC_SRC_LINK: led_next[g] = i_status.link_up;
                    plc_pkg::PLC_SRC_ACT:
                        led_next[g] = i_status.tx_act | i_status.rx_act;
                    plc_pkg::PLC_SRC_TX: led_next[g] = i_status.tx_act;
                    plc_pkg::PLC_SRC_RX: led_next[g] = i_status.rx_act;
                    plc_pkg::PLC_SRC_COL: led_next[g] = i_status.collision;
                    plc_pkg::PLC_SRC_SPD100:
                        led_next[g] = i_status.link_up & i_status.speed_100;
                    plc_pkg::PLC_SRC_SPD10:
                        led_next[g] = i_status.link_up & ~i_status.speed_100;
                    plc_pkg::PLC_SRC_FDX: led_next[g] = i_status.full_duplex;
                    // Link on, blinking during activity
                    plc_pkg::PLC_SRC_LINK_BLINK:
                        led_next[g] = i_status.link_up
                            & ~((i_status.tx_act | i_status.rx_act)
                            & blink_reg);
                    plc_pkg::PLC_SRC_STRETCH: led_next[g] = i_status.act_stretch;
                    plc_pkg::PLC_SRC_LINK100FD:
                        led_next[g] = i_status.link_up & i_status.speed_100
                            & i_status.full_duplex;
                    plc_pkg::PLC_SRC_LPI: led_next[g] = i_status.lpi;
                    plc_pkg::PLC_SRC_MII_ERR: led_next[g] = i_status.mii_err;
                    plc_pkg::PLC_SRC_LINK_LOST: led_next[g] = link_lost_reg;
                    plc_pkg::PLC_SRC_PRBS_ERR: led_next[g] = prbs_hold_reg;
                    // Reserved code keeps the indicator dark
                    default: led_next[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Indicator outputs, registered
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            led_reg <= 3'b000;
        else
            led_reg <= led_next;
    end

    assign o_rdata = rdata_reg;
    assign o_line_cfg = line_reg;
    assign o_led = led_reg;

    // Checks
    a_link_lost_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        link_drop |=> link_lost_reg) else $error("link lost not latched");
    a_link_lost_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        status_read && !link_drop |=> !link_lost_reg)
        else $error("link lost not cleared");
    a_prbs_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        i_status.prbs_err |=> prbs_hold_reg) else $error("prbs not held");
    a_prbs_stays: assert property (@(posedge i_clk) disable iff (i_reset)
        prbs_hold_reg && !i_status.prbs_clear |=> prbs_hold_reg)
        else $error("prbs dropped early");
    a_gap_short: assert property (@(posedge i_clk) disable iff (i_reset)
        general_config_reg[3] |=> o_line_cfg.min_gap_cycles == 3'd3)
        else $error("short gap count wrong");
    a_gap_long: assert property (@(posedge i_clk) disable iff (i_reset)
        !general_config_reg[3] |=> o_line_cfg.min_gap_cycles == 3'd4)
        else $error("long gap count wrong");
    a_term_write: assert property (@(posedge i_clk) disable iff (i_reset)
        i_wr && i_addr == `PLC_OFF_TERM ##1 1 |=>
        o_line_cfg.straight_termination_code == $past(i_wdata[15:12], 2))
        else $error("termination code not applied");
    a_led_link: assert property (@(posedge i_clk) disable iff (i_reset)
        ledsel_reg[7:4] == 4'h0 |=> o_led[0] == $past(i_status.link_up))
        else $error("first indicator wrong");
    a_read_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        !i_rd |=> o_rdata == 16'h0000) else $error("read data stale");

    // Write of the indicator selector word
    sequence s_ledsel_write;
        i_wr && i_addr == `PLC_OFF_LEDSEL;
    endsequence

    // Latched link loss while the first indicator shows it
    sequence s_lost_shown;
        ledsel_reg[7:4] == 4'hD && link_lost_reg;
    endsequence

    // Selector word stored whole on a write
    a_ledsel_store: assert property (
        @(posedge i_clk) disable iff (i_reset)
        s_ledsel_write |=> ledsel_reg == $past(i_wdata))
        else $error("indicator select not stored");
    // Latched loss reaches the pin one edge later
    a_lost_led: assert property (
        @(posedge i_clk) disable iff (i_reset)
        s_lost_shown |=> o_led[0])
        else $error("link lost not shown");
    // Reserved source keeps the first indicator dark
    a_rsvd_dark: assert property (
        @(posedge i_clk) disable iff (i_reset)
        ledsel_reg[7:4] == 4'hF |=> !o_led[0])
        else $error("reserved source lit");
    // Third indicator on collision source
    a_led_third: assert property (
        @(posedge i_clk) disable iff (i_reset)
        ledsel_reg[15:12] == 4'h4 |=> o_led[2] == $past(i_status.collision))
        else $error("third indicator wrong");
    // Second indicator on full duplex source
    a_led_second: assert property (
        @(posedge i_clk) disable iff (i_reset)
        ledsel_reg[11:8] == 4'h7 |=> o_led[1] == $past(i_status.full_duplex))
        else $error("second indicator wrong");
    // Crossed code follows its register one edge behind
    a_cross_code: assert property (
        @(posedge i_clk) disable iff (i_reset)
        1'b1 |=> o_line_cfg.crossed_termination_code == $past(term_reg[10:7]))
        else $error("crossed code not applied");
    // Override enables follow their bits
    a_over_en: assert property (
        @(posedge i_clk) disable iff (i_reset)
        1'b1 |=> o_line_cfg.straight_termination_override == $past(term_reg[11])
            && o_line_cfg.crossed_termination_override == $past(term_reg[6]))
        else $error("override enable wrong");
    // Gain field follows its register
    a_gain_copy: assert property (
        @(posedge i_clk) disable iff (i_reset)
        1'b1 |=> o_line_cfg.rx_comparator_gain == $past(gain_reg[4:0]))
        else $error("gain not applied");
    // Read of the termination word returns it whole
    a_read_term: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_rd && i_addr == `PLC_OFF_TERM |=> o_rdata == $past(term_reg))
        else $error("termination read wrong");

endmodule // plc_bank

// [include/plc_defs.svh]
// Offsets, field positions, reset values and timing counts for the
// line and indicator configuration bank.
// Assumes a 16-bit register port and a 20 MHz core clock.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

// Register offsets (word addresses on the register port)
`define PLC_OFF_TERM 11'h30E
`define PLC_OFF_LDPROG 11'h404
`define PLC_OFF_GAIN 11'h40D
`define PLC_OFF_GENERAL_CONFIG 11'h456
`define PLC_OFF_LEDSEL 11'h460
`define PLC_OFF_BASIC_STATUS 11'h001

// Reset values
`define PLC_RST_TERM 16'h8400
`define PLC_RST_LDPROG 16'h0080
`define PLC_RST_GAIN 16'h0008
`define PLC_RST_GENERAL_CONFIG 16'h0008
`define PLC_RST_LEDSEL 16'h5665

// Writable masks; other bits read back their reset value
`define PLC_WMASK_TERM 16'hFFFC
`define PLC_WMASK_GAIN 16'hFFFF
`define PLC_WMASK_GENERAL_CONFIG 16'hFFFF

// Field positions
`define PLC_STR_CODE_HI 15
`define PLC_STR_CODE_LO 12
`define PLC_STR_OVR_BIT 11
`define PLC_CRS_CODE_HI 10
`define PLC_CRS_CODE_LO 7
`define PLC_CRS_OVR_BIT 6
`define PLC_GAIN_HI 4
`define PLC_GAIN_LO 0
`define PLC_SHORT_GAP_BIT 3

// Inter-packet gap times and derived cycle counts at 20 MHz
`define PLC_CLK_NS 50
`define PLC_GAP_LONG_NS 200
`define PLC_GAP_SHORT_NS 120
`define PLC_GAP_LONG_CYC \
    ((`PLC_GAP_LONG_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)
`define PLC_GAP_SHORT_CYC \
    ((`PLC_GAP_SHORT_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)

// Blink half period for blinking indicator sources
`define PLC_BLINK_CYC 20'd1000000

`endif

// [include/plc_pkg.sv]
// Types for the line and indicator configuration bank.
// Assumes plc_defs.svh is compiled alongside.
package plc_pkg;

    // Indicator source codes
    typedef enum logic [3:0] {
        PLC_SRC_LINK = 4'h0,
        PLC_SRC_ACT = 4'h1,
        PLC_SRC_TX = 4'h2,
        PLC_SRC_RX = 4'h3,
        PLC_SRC_COL = 4'h4,
        PLC_SRC_SPD100 = 4'h5,
        PLC_SRC_SPD10 = 4'h6,
        PLC_SRC_FDX = 4'h7,
        PLC_SRC_LINK_BLINK = 4'h8,
        PLC_SRC_STRETCH = 4'h9,
        PLC_SRC_LINK100FD = 4'hA,
        PLC_SRC_LPI = 4'hB,
        PLC_SRC_MII_ERR = 4'hC,
        PLC_SRC_LINK_LOST = 4'hD,
        PLC_SRC_PRBS_ERR = 4'hE,
        PLC_SRC_RSVD = 4'hF
    } plc_src_t;

    // Live status from the PHY core
    typedef struct packed {
        logic link_up;
        logic tx_act;
        logic rx_act;
        logic collision;
        logic speed_100;
        logic full_duplex;
        logic act_stretch;
        logic lpi;
        logic mii_err;
        logic prbs_err;
        logic prbs_clear;
    } plc_status_t;

    // Line configuration towards the analog front end
    typedef struct packed {
        logic [3:0] straight_termination_code;
        logic straight_termination_override;
        logic [3:0] crossed_termination_code;
        logic crossed_termination_override;
        logic [4:0] rx_comparator_gain;
        logic short_gap_select;
        logic [2:0] min_gap_cycles;
    } plc_line_cfg_t;

endpackage

// [tb/plc_led_far.sv]
// Far-side model: the status source that the indicator selectors watch.
// Assumes one clock; the requested levels land just after each edge.
`timescale 1ns/1ps

module plc_led_far (
    input wire logic i_clk,
    input wire plc_pkg::plc_status_t i_want,
    output plc_pkg::plc_status_t o_status
);
    // Status levels move only after an edge, like the PHY core
    always_ff @(posedge i_clk)
    begin
        o_status <= i_want;
    end
endmodule // plc_led_far

// [tb/tb_top.sv]
// Self-checking bench for the line and indicator configuration bank.
// Assumes plc_pkg and plc_defs.svh are compiled first.
`timescale 1ns/1ps

module tb_top;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [10:0] i_addr = 11'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    plc_pkg::plc_status_t want = '0;
    plc_pkg::plc_status_t i_status;
    logic [15:0] o_rdata;
    plc_pkg::plc_line_cfg_t o_line_cfg;
    logic [2:0] o_led;
    logic [15:0] rv;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    logic [10:0] pat [4] = '{11'h668, 11'h594, 11'h000, 11'h400};

    plc_bank plc_bank_inst (.i_clk(i_clk), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_status(i_status), .o_rdata(o_rdata),
        .o_line_cfg(o_line_cfg), .o_led(o_led));
    plc_led_far plc_led_far_inst (.i_clk(i_clk), .i_want(want),
        .o_status(i_status));

    // 20 MHz clock
    always #25 i_clk = ~i_clk;

    // Hang guard
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [10:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [10:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk({16'h0000, d}, {16'h0000, exp});
    endtask

    // Indicator level expected from a source code and the status
    function automatic logic exp_led(input logic [3:0] c,
        input plc_pkg::plc_status_t s);
        case (c)
            4'h0: return s.link_up;
            4'h1: return s.tx_act | s.rx_act;
            4'h2: return s.tx_act;
            4'h3: return s.rx_act;
            4'h4: return s.collision;
            4'h5: return s.link_up & s.speed_100;
            4'h6: return s.link_up & ~s.speed_100;
            4'h7: return s.full_duplex;
            4'h8: return s.link_up;
            4'h9: return s.act_stretch;
            4'hA: return s.link_up & s.speed_100 & s.full_duplex;
            4'hB: return s.lpi;
            4'hC: return s.mii_err;
            default: return 1'b0;
        endcase
    endfunction

    initial
    begin
        plc_pkg::plc_status_t s;
        logic e;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        wait_cyc(3);
        chk_reg(11'h30E, 16'h8400);
        chk_reg(11'h404, 16'h0080);
        chk_reg(11'h40D, 16'h0008);
        chk_reg(11'h456, 16'h0008);
        chk_reg(11'h460, 16'h5665);
        chk(o_line_cfg, {4'h8, 1'b0, 4'h8, 1'b0, 5'h08, 1'b1, 3'd3});
        chk(o_led, 3'b000);
        $display("test reset done");
        wr(11'h30E, 16'hFFFF);
        chk_reg(11'h30E, 16'hFFFC);
        wr(11'h40D, 16'hFFFF);
        chk_reg(11'h40D, 16'hFFFF);
        wr(11'h404, 16'h1234);
        chk_reg(11'h404, 16'h1234);
        wr(11'h123, 16'hFFFF);
        chk_reg(11'h123, 16'h0000);
        chk_reg(11'h460, 16'h5665);
        wait_cyc(3);
        chk(o_line_cfg, {4'hF, 1'b1, 4'hF, 1'b1, 5'h1F, 1'b1, 3'd3});
        wr(11'h456, 16'h0000);
        chk_reg(11'h456, 16'h0000);
        wr(11'h30E, 16'h2380);
        wait_cyc(3);
        chk(o_line_cfg, {4'h2, 1'b0, 4'h7, 1'b0, 5'h1F, 1'b0, 3'd4});
        $display("test line config done");
        // Low nibble keeps its reset value
        wr(11'h460, 16'h0475);
        want <= pat[1];
        wait_cyc(3);
        chk(o_led, 3'b110);
        want <= pat[0];
        wait_cyc(3);
        chk(o_led, 3'b101);
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 13; c++)
            begin
                s = pat[p];
                // Blinking source only checked without activity
                if (c == 8 && p < 2)
                    continue;
                wr(11'h460, {c[3:0], c[3:0], c[3:0], 4'h5});
                want <= s;
                wait_cyc(3);
                e = exp_led(c[3:0], s);
                chk(o_led, {e, e, e});
            end
        $display("test sources done");
        want <= 11'h7FC;
        wr(11'h460, 16'hFFF5);
        wait_cyc(3);
        chk(o_led, 3'b000);
        want <= 11'h400;
        wr(11'h460, 16'hDDD5);
        // Earlier source scans dropped the link; clear the latch first
        chk_reg(11'h001, 16'h0000);
        wait_cyc(3);
        chk(o_led, 3'b000);
        want <= 11'h000;
        wait_cyc(3);
        chk(o_led, 3'b111);
        want <= 11'h400;
        wait_cyc(3);
        chk(o_led, 3'b111);
        chk_reg(11'h001, 16'h0000);
        wait_cyc(3);
        chk(o_led, 3'b000);
        $display("test link lost done");
        wr(11'h460, 16'hEEE5);
        @(posedge i_clk);
        want <= 11'h002;
        @(posedge i_clk);
        want <= 11'h000;
        wait_cyc(8);
        chk(o_led, 3'b111);
        want <= 11'h001;
        @(posedge i_clk);
        want <= 11'h000;
        wait_cyc(3);
        chk(o_led, 3'b000);
        $display("test error hold done");
        final_report();
    end
endmodule // tb_top
